// ===== design/rpm_ctrl.sv
/*
 Reset and low-power mode sequencer with APB register access.
 Assumes clk is the oscillator clock; rst pin, wake pins arrive asynchronously.
*/
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rpm_ctrl
   import rpm_pkg::*;
#(
   parameter int AW = 8
) (
   // Clock, reset, enable
   input  wire logic          clk,
   input  wire logic          rstn,
   input  wire logic          ce,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [AW-1:0] paddr,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic [31:0]        prdata,
   output logic               pslverr,
   // Reset pin (active high, two-way) and sources
   input  wire logic          rst_pin_i,
   output logic               rst_pin_o,
   output logic               rst_pin_oe,
   input  wire logic          wdt_expire,
   input  wire logic          boot_jump_fuse,
   output logic               core_rst,
   output logic               boot_map_enable,
   // Wake sources
   input  wire logic          ext_irq_zero_n,
   input  wire logic          external_irq_one_n,
   input  wire logic          kbd_irq,
   input  wire logic          irq_pending,
   output logic               wake_irq,
   output logic [1:0]         wake_src,
   // Clock gating
   output logic               cpu_clk_en,
   output logic               periph_clk_en,
   output logic               osc_run,
   output logic               ram_hold,
   // Ports and strobes from core, and to pins
   input  wire logic [7:0]    p0_d,
   input  wire logic          p0_drv,
   input  wire logic [7:0]    p1_d,
   input  wire logic [7:0]    p2_d,
   input  wire logic [7:0]    p2_addr,
   input  wire logic [7:0]    p3_d,
   input  wire logic          ale_d,
   input  wire logic          program_store_strobe_d,
   output logic [7:0]         p0_o,
   output logic [7:0]         p0_oe,
   output logic [7:0]         p1_o,
   output logic [7:0]         p2_o,
   output logic [7:0]         p3_o,
   output logic               ale,
   output logic               program_store_strobe
);

   // Address match
   function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] ofs);
      hit = (a == AW'(ofs));
   endfunction : hit

   rpm_state_e       state_r;
   logic [3:0]       power_control_reg_r;
   logic [5:0]       cfg_r;
   logic [1:0]       rs_r, e0_r, e1_r;
   logic             rst_s, e0_s, e1_s;
   logic [CNT_W-1:0] rst_cnt_r, wdt_cnt_r, kw_cnt_r;
   logic             rst_acc_r, rst_acc_q, held0_r, held1_r;
   logic [7:0]       h0_r, h1_r, h2_r, h3_r;
   logic             wr_en, rd_en, mapped, pd_done;

   // Two-flop synchronisers; logic reads only the second stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rs_r <= 2'h0;
         e0_r <= 2'h3;
         e1_r <= 2'h3;
      end else if (ce) begin
         rs_r <= {rs_r[0], rst_pin_i};
         e0_r <= {e0_r[0], ext_irq_zero_n};
         e1_r <= {e1_r[0], external_irq_one_n};
      end
   end
   assign rst_s = rs_r[1];
   assign e0_s  = e0_r[1];
   assign e1_s  = e1_r[1];

   // APB decode
   assign wr_en  = psel & penable & ~pready & pwrite;
   assign rd_en  = psel & penable & ~pready & ~pwrite;
   assign mapped = hit(paddr, OFS_POWER_CONTROL_REG) | hit(paddr, OFS_AUX) |
                   hit(paddr, OFS_CFG) | hit(paddr, OFS_STAT);

   // APB answer one cycle into the access phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         prdata  <= 32'h0;
         if (rd_en) begin
            if (hit(paddr, OFS_POWER_CONTROL_REG)) prdata[3:0] <= power_control_reg_r;
            if (hit(paddr, OFS_AUX)) prdata[AUX_BOOT] <= boot_map_enable;
            if (hit(paddr, OFS_CFG)) prdata[5:0] <= cfg_r;
            if (hit(paddr, OFS_STAT)) begin
               prdata[ST_IDLE_B] <= (state_r == RPM_IDLE);
               prdata[ST_PD_B]   <= (state_r == RPM_PDOWN);
               prdata[ST_KW_B]   <= (state_r == RPM_KWAIT);
               prdata[ST_RST_B]  <= rst_acc_r;
               prdata[ST_SRC_LO +: 2] <= wake_src;
            end
         end
      end
   end

   // Reset length counted in raw clocks; double speed bit not consulted
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_cnt_r <= '0;
         rst_acc_r <= 1'b0;
      end else if (ce) begin
         if (!rst_s) begin
            rst_cnt_r <= '0;
            rst_acc_r <= 1'b0;
         end else if (osc_run && !rst_acc_r) begin
            rst_cnt_r <= rst_cnt_r + CNT_W'(1);
            if (rst_cnt_r == CNT_W'(RST_MIN_CLK - 1))
               rst_acc_r <= 1'b1;
         end
      end
   end

   // Watchdog drives the reset pin high for a fixed pulse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wdt_cnt_r  <= '0;
         rst_pin_o  <= 1'b0;
         rst_pin_oe <= 1'b0;
      end else if (ce) begin
         if (wdt_expire && wdt_cnt_r == '0) begin
            wdt_cnt_r  <= CNT_W'(WDT_PULSE_CLK);
            rst_pin_o  <= 1'b1;
            rst_pin_oe <= 1'b1;
         end else if (wdt_cnt_r != '0) begin
            wdt_cnt_r <= wdt_cnt_r - CNT_W'(1);
            if (wdt_cnt_r == CNT_W'(1)) begin
               rst_pin_o  <= 1'b0;
               rst_pin_oe <= 1'b0;
            end
         end
      end
   end

   // Core reset and boot mapping load; fuse sampled after release too
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         core_rst        <= 1'b1;
         rst_acc_q       <= 1'b1;
         boot_map_enable <= 1'b0;
      end else if (ce) begin
         rst_acc_q <= rst_acc_r;
         core_rst  <= rst_acc_r;
         if (rst_acc_q && !rst_acc_r)
            boot_map_enable <= boot_jump_fuse;
         else if (wr_en && hit(paddr, OFS_AUX))
            boot_map_enable <= pwdata[AUX_BOOT];
      end
   end

   // Power-down exit on release of a held pin
   assign pd_done = (held0_r & e0_s) | (held1_r & e1_s);

   // Mode sequencer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r  <= RPM_RUN;
         held0_r  <= 1'b0;
         held1_r  <= 1'b0;
         kw_cnt_r <= '0;
         wake_irq <= 1'b0;
         wake_src <= SRC_EXT0;
      end else if (ce) begin
         wake_irq <= 1'b0;
         if (rst_acc_r) begin
            state_r <= RPM_RUN;
            held0_r <= 1'b0;
            held1_r <= 1'b0;
         end else begin
            unique case (state_r)
               RPM_RUN: begin
                  // Hold off while the wake clear of the request bits lands
                  if (wake_irq)
                     state_r <= RPM_RUN;
                  else if (power_control_reg_r[PC_PD])
                     state_r <= RPM_PDOWN;
                  else if (power_control_reg_r[PC_IDLE])
                     state_r <= RPM_IDLE;
               end
               RPM_IDLE: begin
                  if (irq_pending) begin
                     state_r  <= RPM_RUN;
                     wake_irq <= 1'b1;
                     wake_src <= SRC_IRQ;
                  end
               end
               RPM_PDOWN: begin
                  if (cfg_r[CF_EN0] && !e0_s) held0_r <= 1'b1;
                  if (cfg_r[CF_EN1] && !e1_s) held1_r <= 1'b1;
                  if (pd_done) begin
                     state_r  <= RPM_RUN;
                     wake_irq <= 1'b1;
                     held0_r  <= 1'b0;
                     held1_r  <= 1'b0;
                     if (held0_r && held1_r)
                        wake_src <= cfg_r[CF_PRI1] ? SRC_EXT1 : SRC_EXT0;
                     else
                        wake_src <= held1_r ? SRC_EXT1 : SRC_EXT0;
                  end else if (cfg_r[CF_ENK] && kbd_irq) begin
                     state_r  <= RPM_KWAIT;
                     kw_cnt_r <= '0;
                  end
               end
               RPM_KWAIT: begin
                  kw_cnt_r <= kw_cnt_r + CNT_W'(1);
                  if (kw_cnt_r == CNT_W'(KBD_WAKE_CLK - 1)) begin
                     state_r  <= RPM_RUN;
                     wake_irq <= 1'b1;
                     wake_src <= SRC_KBD;
                  end
               end
            endcase
         end
      end
   end

   // power_control_reg: software sets, hardware clears the mode bits on wake and the whole register on reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         power_control_reg_r <= POWER_CONTROL_REG_RST;
      end else if (ce) begin
         if (rst_acc_r)
            power_control_reg_r <= POWER_CONTROL_REG_RST;
         else if (wr_en && hit(paddr, OFS_POWER_CONTROL_REG))
            power_control_reg_r <= pwdata[3:0];
         else if (wake_irq)
            power_control_reg_r[PC_PD:PC_IDLE] <= 2'h0;
      end
   end

   // Configuration register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         cfg_r <= CFG_RST;
      else if (ce && rst_acc_r)
         cfg_r <= CFG_RST;
      else if (ce && wr_en && hit(paddr, OFS_CFG))
         cfg_r <= pwdata[5:0];
   end

   // Clock gates: oscillator restarts while an enabled wake pin or reset is held
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_clk_en    <= 1'b1;
         periph_clk_en <= 1'b1;
         osc_run       <= 1'b1;
         ram_hold      <= 1'b0;
      end else if (ce) begin
         cpu_clk_en    <= (state_r == RPM_RUN) && !wake_irq && !power_control_reg_r[PC_IDLE]
                          && !power_control_reg_r[PC_PD];
         periph_clk_en <= (state_r == RPM_RUN) || (state_r == RPM_IDLE);
         osc_run       <= (state_r != RPM_PDOWN) || rst_s || held0_r || held1_r
                          || (cfg_r[CF_EN0] && !e0_s)
                          || (cfg_r[CF_EN1] && !e1_s);
         ram_hold      <= (state_r == RPM_PDOWN) || (state_r == RPM_KWAIT);
      end
   end

   // Port levels captured at low-power entry
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         h0_r <= 8'hFF;
         h1_r <= 8'hFF;
         h2_r <= 8'hFF;
         h3_r <= 8'hFF;
      end else if (ce && state_r == RPM_RUN) begin
         h0_r <= p0_d;
         h1_r <= p1_d;
         h2_r <= p2_d;
         h3_r <= p3_d;
      end
   end

   // Pin drive per mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         p0_o <= 8'h00;
         p0_oe <= 8'h00;
         p1_o <= 8'hFF;
         p2_o <= 8'hFF;
         p3_o <= 8'hFF;
         ale <= 1'b1;
         program_store_strobe <= 1'b1;
      end else if (ce) begin
         if (state_r == RPM_RUN) begin
            p0_o  <= p0_d;
            p0_oe <= {8{p0_drv}};
            p1_o  <= p1_d;
            p2_o  <= p2_d;
            p3_o  <= p3_d;
            ale   <= ale_d;
            program_store_strobe <= program_store_strobe_d;
         end else begin
            p0_o  <= 8'h00;
            p0_oe <= cfg_r[CF_EXTMEM] ? 8'h00 : ~h0_r;
            p1_o  <= h1_r;
            p2_o  <= (state_r == RPM_IDLE && cfg_r[CF_EXTMEM]) ? p2_addr : h2_r;
            p3_o  <= h3_r;
            ale   <= (state_r == RPM_IDLE);
            program_store_strobe <= (state_r == RPM_IDLE);
         end
      end
   end

   // Checks
   a_rst_min_len: assert property (@(posedge clk) disable iff (!rstn)
      $rose(rst_acc_r) |-> $past(rst_s, RST_MIN_CLK))
      else $error("reset accepted too early");
   a_wdt_pulse: assert property (@(posedge clk) disable iff (!rstn)
      ce && wdt_expire && !rst_pin_oe ##1 ce[*8] |-> rst_pin_oe[*8])
      else $error("watchdog pulse too short");
   a_boot_load: assert property (@(posedge clk) disable iff (!rstn)
      ce && $fell(rst_acc_r) && rst_acc_q |=> boot_map_enable == $past(boot_jump_fuse))
      else $error("boot map not loaded from fuse");
   a_idle_clocks: assert property (@(posedge clk) disable iff (!rstn)
      ce && state_r == RPM_IDLE ##1 ce |-> !cpu_clk_en && periph_clk_en)
      else $error("idle clock gating wrong");
   a_idle_strobes: assert property (@(posedge clk) disable iff (!rstn)
      ce && state_r == RPM_IDLE ##1 ce |-> ale && program_store_strobe)
      else $error("strobes not high in idle");
   a_idle_wake: assert property (@(posedge clk) disable iff (!rstn)
      ce && state_r == RPM_IDLE && irq_pending && !rst_acc_r ##1 ce[*2]
      |-> !power_control_reg_r[PC_IDLE])
      else $error("idle bit not cleared");
   a_pd_strobes: assert property (@(posedge clk) disable iff (!rstn)
      ce && state_r == RPM_PDOWN ##1 ce |-> !ale && !program_store_strobe)
      else $error("strobes not low in power-down");
   a_pd_priority: assert property (@(posedge clk) disable iff (!rstn)
      ce && state_r == RPM_RUN && power_control_reg_r[PC_PD] && power_control_reg_r[PC_IDLE] && !rst_acc_r
      && !wake_irq |=> state_r == RPM_PDOWN)
      else $error("idle taken over power-down");
   a_wake_stays_run: assert property (@(posedge clk) disable iff (!rstn)
      ce && wake_irq && !wr_en |=> state_r == RPM_RUN && !power_control_reg_r[PC_PD] && !power_control_reg_r[PC_IDLE])
      else $error("low power entered again after wake");
   a_reset_clears: assert property (@(posedge clk) disable iff (!rstn)
      ce && rst_acc_r |=> state_r == RPM_RUN && power_control_reg_r == POWER_CONTROL_REG_RST && cfg_r == CFG_RST)
      else $error("reset exit left registers set");
   a_pd_ram_hold: assert property (@(posedge clk) disable iff (!rstn)
      ce && state_r == RPM_PDOWN ##1 ce |-> ram_hold)
      else $error("ram not held in power-down");
   a_kbd_wait: assert property (@(posedge clk) disable iff (!rstn)
      state_r == RPM_KWAIT && kw_cnt_r < CNT_W'(KBD_WAKE_CLK - 1) && !rst_acc_r
      |=> state_r != RPM_RUN)
      else $error("keyboard wake too early");
   a_p0_low_only: assert property (@(posedge clk) disable iff (!rstn)
      ce && state_r != RPM_RUN ##1 ce |-> p0_o == 8'h00)
      else $error("port 0 drives high in low power");

endmodule : rpm_ctrl
`default_nettype wire

// ===== design/rpm_pkg.sv
/*
 Constants, offsets and state type for the reset and power mode controller.
 Assumes a 32-bit APB slave with byte addresses; one aligned word a register.
*/
`default_nettype none
package rpm_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_POWER_CONTROL_REG = 8'h00;
   localparam logic [7:0] OFS_AUX  = 8'h04;
   localparam logic [7:0] OFS_CFG  = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   // power_control_reg fields
   localparam int PC_IDLE = 0;
   localparam int PC_PD   = 1;
   localparam int PC_GF0  = 2;
   localparam int PC_GF1  = 3;
   // auxiliary_control_reg field
   localparam int AUX_BOOT = 0;
   // Configuration fields
   localparam int CF_EXTMEM = 0;
   localparam int CF_EN0    = 1;
   localparam int CF_EN1    = 2;
   localparam int CF_ENK    = 3;
   localparam int CF_PRI1   = 4;
   localparam int CF_X2     = 5;
   // Status fields
   localparam int ST_IDLE_B = 0;
   localparam int ST_PD_B   = 1;
   localparam int ST_KW_B   = 2;
   localparam int ST_RST_B  = 3;
   localparam int ST_SRC_LO = 4;
   // Reset values
   localparam logic [3:0] POWER_CONTROL_REG_RST = 4'h0;
   localparam logic [5:0] CFG_RST  = 6'h00;
   // Wake source codes
   localparam logic [1:0] SRC_EXT0 = 2'h0;
   localparam logic [1:0] SRC_EXT1 = 2'h1;
   localparam logic [1:0] SRC_KBD  = 2'h2;
   localparam logic [1:0] SRC_IRQ  = 2'h3;
   // Timing in oscillator clocks
   localparam int RST_MIN_CLK   = 24;
   localparam int WDT_PULSE_CLK = 96;
   localparam int KBD_WAKE_CLK  = 1024;
   localparam int CNT_W         = 11;
   typedef enum logic [1:0] {RPM_RUN, RPM_IDLE, RPM_PDOWN, RPM_KWAIT} rpm_state_e;
endpackage : rpm_pkg
`default_nettype wire

// ===== testbench/rpm_far_end.sv
/*
 Far-side model: external reset circuit and the two wake pins.
 Assumes rising-edge clk; pins change just after an edge.
*/
`timescale 1ns/100ps
`default_nettype none
module rpm_far_end (
   // Clock
   input  wire logic clk,
   // Reset pin, shared with the device drive
   input  wire logic rst_pin_o,
   input  wire logic rst_pin_oe,
   output logic      rst_lvl,
   // Wake pins, active low
   output logic      ext0_n,
   output logic      ext1_n
);
   logic rst_drv;
   // Pull-down on the pin: level is either party's drive
   assign rst_lvl = (rst_pin_oe & rst_pin_o) | rst_drv;
   // Released pins rest at their pull levels
   initial begin
      rst_drv = 1'b0;
      ext0_n  = 1'b1;
      ext1_n  = 1'b1;
   end
   // Holds reset for n clocks, then lets the pull-down win
   task pin_reset(input int n);
      @(posedge clk) rst_drv <= 1'b1;
      repeat (n) @(posedge clk);
      rst_drv <= 1'b0;
   endtask : pin_reset
   // Holds masked pins low: pin zero for n clocks, then pin one 5 clocks later
   task hold(input logic [1:0] m, input int n);
      @(posedge clk);
      ext0_n <= ~m[0];
      ext1_n <= ~m[1];
      repeat (n) @(posedge clk);
      ext0_n <= 1'b1;
      repeat (5) @(posedge clk);
      ext1_n <= 1'b1;
   endtask : hold
endmodule : rpm_far_end
`default_nettype wire

// ===== testbench/tb_reset_and_power_mode_control.sv
/*
 Self-checking bench for the reset and power mode sequencer.
 Assumes rpm_ctrl, rpm_pkg and the far-side model rpm_far_end.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_reset_and_power_mode_control;
   import rpm_pkg::*;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr, errf;
   logic        rst_lvl, rst_pin_o, rst_pin_oe, wdt_expire, boot_jump_fuse;
   logic        core_rst, boot_map_enable, ext_irq_zero_n, external_irq_one_n;
   logic        kbd_irq, irq_pending, wake_irq, cpu_clk_en, periph_clk_en;
   logic        osc_run, ram_hold, p0_drv, ale_d, program_store_strobe_d, ale, program_store_strobe;
   logic [7:0]  paddr, p0_d, p1_d, p2_d, p2_addr, p3_d, p0_o, p0_oe, p1_o, p2_o, p3_o;
   logic [31:0] pwdata, prdata, rdat;
   logic [1:0]  wake_src;
   int          fails, compares, cycles, wc;

   rpm_ctrl i_rpm_ctrl (
      .clk, .rstn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .rst_pin_i(rst_lvl), .rst_pin_o, .rst_pin_oe, .wdt_expire,
      .boot_jump_fuse, .core_rst, .boot_map_enable, .ext_irq_zero_n,
      .external_irq_one_n, .kbd_irq, .irq_pending, .wake_irq, .wake_src, .cpu_clk_en,
      .periph_clk_en, .osc_run, .ram_hold, .p0_d, .p0_drv, .p1_d, .p2_d, .p2_addr,
      .p3_d, .ale_d, .program_store_strobe_d, .p0_o, .p0_oe, .p1_o, .p2_o, .p3_o, .ale,
      .program_store_strobe
   );
   rpm_far_end i_rpm_far_end (
      .clk, .rst_pin_o, .rst_pin_oe, .rst_lvl, .ext0_n(ext_irq_zero_n),
      .ext1_n(external_irq_one_n)
   );

   // Clock and hang guard
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         $display("wrong value at %0t: run hung", $time);
         finish_test;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; held until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      errf = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rdchk

   // Counts falling edges until the wake pulse, at most lim
   task wait_wake(input int lim);
      wc = 0;
      do begin
         @(negedge clk);
         wc++;
      end while (wake_irq !== 1'b1 && wc < lim);
   endtask : wait_wake

   task t_reset_vals;
      rdchk(OFS_POWER_CONTROL_REG, 32'h0);
      rdchk(OFS_CFG, 32'h0);
      rdchk(OFS_AUX, 32'h1);
      rdchk(8'h10, 32'h0);
      chk(32'(errf), 32'h1);
   endtask : t_reset_vals

   // Idle with external memory, both flags set on entry
   task t_idle;
      apb(1'b1, OFS_CFG, 32'h01);
      p1_d    <= 8'h3C;
      p2_addr <= 8'h77;
      apb(1'b1, OFS_POWER_CONTROL_REG, 32'h0D);
      repeat (3) @(negedge clk);
      chk(32'({cpu_clk_en, periph_clk_en}), 32'h1);
      chk(32'({ale, program_store_strobe}), 32'h3);
      chk(32'(p0_oe), 32'h0);
      chk(32'(p2_o), 32'h77);
      rdchk(OFS_STAT, 32'h1);
      @(posedge clk) p1_d <= 8'hC3;
      @(negedge clk);
      chk(32'(p1_o), 32'h3C);
      @(posedge clk) irq_pending <= 1'b1;
      wait_wake(20);
      chk(32'(wake_src), 32'(SRC_IRQ));
      @(posedge clk) irq_pending <= 1'b0;
      rdchk(OFS_POWER_CONTROL_REG, 32'hC);
      chk(32'(cpu_clk_en), 32'h1);
   endtask : t_idle

   // Power-down with both request bits, woken by held pins
   task pd_case(input logic [31:0] cfg, input logic [1:0] m, input logic [1:0] src);
      apb(1'b1, OFS_CFG, cfg);
      p0_d   <= 8'hA5;
      p0_drv <= 1'b1;
      p3_d   <= 8'h5A;
      ale_d  <= 1'b1;
      program_store_strobe_d <= 1'b1;
      apb(1'b1, OFS_POWER_CONTROL_REG, 32'h03);
      repeat (3) @(negedge clk);
      chk(32'({osc_run, ram_hold, ale, program_store_strobe}), 32'h4);
      chk(32'(p0_oe), 32'h5A);
      chk(32'(p0_o & p0_oe), 32'h0);
      @(posedge clk);
      irq_pending <= 1'b1;
      p3_d        <= 8'h00;
      repeat (10) @(negedge clk);
      chk(32'({osc_run, p3_o}), 32'h5A);
      @(posedge clk) irq_pending <= 1'b0;
      fork
         i_rpm_far_end.hold(m, 30);
         begin
            repeat (20) @(negedge clk);
            chk(32'(osc_run), 32'h1);
            wait_wake(40);
         end
      join
      chk(32'(wake_src), 32'(src));
      rdchk(OFS_STAT, 32'(src) << 4);
      rdchk(OFS_POWER_CONTROL_REG, 32'h0);
      rdchk(OFS_CFG, cfg);
   endtask : pd_case

   // Disabled pins are ignored; keyboard wake takes 1024 clocks
   task t_kbd;
      apb(1'b1, OFS_CFG, 32'h09);
      apb(1'b1, OFS_POWER_CONTROL_REG, 32'h02);
      fork
         i_rpm_far_end.hold(2'b11, 20);
         wait_wake(40);
      join
      chk(32'(wc), 32'd40);
      chk(32'({p0_oe, p2_o}), 32'h0);
      @(posedge clk) kbd_irq <= 1'b1;
      wait_wake(1100);
      chk(32'(wc >= 1024 && wc <= 1030), 32'h1);
      chk(32'(wake_src), 32'(SRC_KBD));
      @(posedge clk) kbd_irq <= 1'b0;
   endtask : t_kbd

   // Short pin pulse refused, long one resets and reloads the fuse
   task t_pin_reset;
      apb(1'b1, OFS_CFG, 32'h20);
      boot_jump_fuse <= 1'b0;
      i_rpm_far_end.pin_reset(23);
      repeat (5) @(negedge clk);
      chk(32'(core_rst), 32'h0);
      rdchk(OFS_CFG, 32'h20);
      i_rpm_far_end.pin_reset(30);
      @(negedge clk);
      chk(32'(core_rst), 32'h1);
      repeat (5) @(negedge clk);
      rdchk(OFS_CFG, 32'h0);
      chk(32'(boot_map_enable), 32'h0);
   endtask : t_pin_reset

   task t_wdt;
      int n;
      n = 0;
      @(posedge clk) wdt_expire <= 1'b1;
      @(posedge clk) wdt_expire <= 1'b0;
      repeat (200) begin
         @(negedge clk);
         if (rst_pin_oe === 1'b1 && rst_pin_o === 1'b1) n++;
      end
      chk(32'(n), 32'd96);
   endtask : t_wdt

   task finish_test;
      if (fails == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test

   // Main sequence
   initial begin
      {clk, rstn, psel, penable, pwrite, wdt_expire, kbd_irq, irq_pending} = '0;
      {p0_drv, ale_d, program_store_strobe_d, paddr, pwdata, p0_d, p1_d, p2_d, p2_addr, p3_d} = '0;
      boot_jump_fuse = 1'b1;
      fails = 0;
      compares = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      t_reset_vals;
      t_idle;
      pd_case(32'h06, 2'b01, SRC_EXT0);
      pd_case(32'h16, 2'b11, SRC_EXT1);
      t_kbd;
      t_pin_reset;
      t_wdt;
      finish_test;
   end
endmodule : tb_reset_and_power_mode_control
`default_nettype wire
